// >>> rtl/asu_pkg.sv
// constants for the async serial unit: register map, fields, resets, encodings
package asu_pkg;
  // =====================================================================
  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;  // operation_mode_register
  localparam logic [7:0] OFS_CLKSEL = 8'h04;  // clock_select_register
  localparam logic [7:0] OFS_BAUD   = 8'h08;  // base clocks per bit
  localparam logic [7:0] OFS_TXBUF  = 8'h0C;  // transmit_buffer
  localparam logic [7:0] OFS_TXSTAT = 8'h10;  // transmit_status_register
  localparam logic [7:0] OFS_RXBUF  = 8'h14;  // received byte
  localparam logic [7:0] OFS_ISTAT  = 8'h18;  // sticky event bits
  localparam logic [7:0] OFS_IMASK  = 8'h1C;  // event mask
  // =====================================================================
  // mode register bit positions
  localparam int BIT_POWER = 7;  // unit_power_enable
  localparam int BIT_TXE   = 6;  // transmit_enable
  localparam int BIT_RXE   = 5;  // receive_enable
  localparam int BIT_INV   = 0;  // serial_out_pin inversion
  // transmit status bit positions
  localparam int BIT_BUSY  = 0;  // transmitter shifting
  localparam int BIT_FULL  = 1;  // transmit_buffer_full_flag
  // event bit positions
  localparam int EV_TXDONE = 0;  // stop bit sent
  localparam int EV_RXDONE = 1;  // byte received
  localparam int EV_RXERR  = 2;  // stop bit found low
  localparam int EV_W      = 3;  // number of events
  // =====================================================================
  // reset values and counts
  localparam logic [7:0] RST_CLKSEL = 8'h00;  // base clock = CLK
  localparam logic [7:0] RST_BAUD   = 8'h10;  // 16 base clocks per bit
  localparam logic [7:0] CNT_ZERO   = 8'h00;  // counter terminal value
  localparam logic [7:0] CNT_ONE    = 8'h01;  // counter step
  localparam logic [7:0] GAP_TICKS  = 8'h02;  // extra base clocks between frames
  localparam logic [2:0] LAST_BIT   = 3'h7;   // index of last data bit
  // =====================================================================
  // state encodings, gray along the usual path
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h3,
    TX_STOP  = 3'h2,
    TX_GAP   = 3'h6
  } asu_tx_st_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } asu_rx_st_t;
endpackage

// >>> rtl/asu_top.sv
// async serial unit: apb registers, base clock, transmitter, receiver, interrupt
`timescale 1ns/10ps
`default_nettype none
module asu_top (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic        SERIAL_IN,
  output var  logic        SERIAL_OUT,
  output var  logic        IRQ
);
  // =====================================================================
  // declarations
  logic [7:0]       mode_q;      // power, enables, inversion
  logic [7:0]       clksel_q;    // base clock divide minus one
  logic [7:0]       baud_q;      // base clocks per bit
  logic [7:0]       div_q;       // base clock divider
  logic             tick;        // base clock enable pulse
  logic             txe_s1_q;    // transmit enable, first tick stage
  logic             txe_s2_q;    // transmit enable, second tick stage
  logic             rxe_s1_q;    // receive enable, first tick stage
  logic             rxe_s2_q;    // receive enable, second tick stage
  logic             tx_on;       // transmitter running
  logic             rx_on;       // receiver running
  asu_pkg::asu_tx_st_t tx_st_q;  // transmit state
  asu_pkg::asu_rx_st_t rx_st_q;  // receive state
  logic [7:0]       tx_cnt_q;    // transmit bit timer
  logic [7:0]       rx_cnt_q;    // receive bit timer
  logic [2:0]       tx_idx_q;    // transmit bit index
  logic [2:0]       rx_idx_q;    // receive bit index
  logic [7:0]       txbuf_q;     // transmit buffer
  logic [7:0]       tx_sh_q;     // transmit shift register
  logic [7:0]       rx_sh_q;     // receive shift register
  logic [7:0]       rxbuf_q;     // last received byte
  logic             full_q;      // transmit buffer full
  logic             tx_load;     // buffer moves to shifter
  logic             tx_line;     // uninverted transmit level
  logic [2:0]       ev;          // event pulses
  logic [2:0]       ist_q;       // sticky events
  logic [2:0]       imask_q;     // event mask
  logic             acc;         // access completes this edge
  logic             wr;          // write completes this edge
  logic             mapped;      // address decodes

  // decode one register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction
  // =====================================================================
  // apb slave: one wait state, write on the completing edge
  assign acc    = PSEL && PENABLE && PREADY;
  assign wr     = acc && PWRITE;
  assign mapped = hit(PADDR, asu_pkg::OFS_MODE) || hit(PADDR, asu_pkg::OFS_CLKSEL) ||
                  hit(PADDR, asu_pkg::OFS_BAUD) || hit(PADDR, asu_pkg::OFS_TXBUF) ||
                  hit(PADDR, asu_pkg::OFS_TXSTAT) || hit(PADDR, asu_pkg::OFS_RXBUF) ||
                  hit(PADDR, asu_pkg::OFS_ISTAT) || hit(PADDR, asu_pkg::OFS_IMASK);

  // ready, read data and error for the access phase
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !PREADY) begin
      PREADY  <= 1'b1;
      PSLVERR <= !mapped;
      PRDATA  <= 32'h0000_0000;
      if (!PWRITE) begin
        case (PADDR)
          asu_pkg::OFS_MODE:   PRDATA[7:0] <= mode_q;
          asu_pkg::OFS_CLKSEL: PRDATA[7:0] <= clksel_q;
          asu_pkg::OFS_BAUD:   PRDATA[7:0] <= baud_q;
          asu_pkg::OFS_TXBUF:  PRDATA[7:0] <= txbuf_q;
          asu_pkg::OFS_TXSTAT: begin
            PRDATA[asu_pkg::BIT_FULL] <= full_q;
            PRDATA[asu_pkg::BIT_BUSY] <= (tx_st_q != asu_pkg::TX_IDLE);
          end
          asu_pkg::OFS_RXBUF:  PRDATA[7:0] <= rxbuf_q;
          asu_pkg::OFS_ISTAT:  PRDATA[2:0] <= ist_q;
          asu_pkg::OFS_IMASK:  PRDATA[2:0] <= imask_q;
          default:             PRDATA <= 32'h0000_0000;
        endcase
      end
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // software control registers
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_q   <= 8'h00;
      clksel_q <= asu_pkg::RST_CLKSEL;
      baud_q   <= asu_pkg::RST_BAUD;
      imask_q  <= 3'h0;
      txbuf_q  <= 8'h00;
    end else if (wr) begin
      if (hit(PADDR, asu_pkg::OFS_MODE))   mode_q   <= PWDATA[7:0];
      if (hit(PADDR, asu_pkg::OFS_CLKSEL)) clksel_q <= PWDATA[7:0];
      if (hit(PADDR, asu_pkg::OFS_BAUD))   baud_q   <= PWDATA[7:0];
      if (hit(PADDR, asu_pkg::OFS_IMASK))  imask_q  <= PWDATA[2:0];
      if (hit(PADDR, asu_pkg::OFS_TXBUF))  txbuf_q  <= PWDATA[7:0];
    end
  end
  // =====================================================================
  // base clock divider, one enable pulse per base clock
  assign tick = (div_q == clksel_q);
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) div_q <= asu_pkg::CNT_ZERO;
    else if (tick) div_q <= asu_pkg::CNT_ZERO;
    else div_q <= div_q + asu_pkg::CNT_ONE;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      txe_s1_q <= 1'b0;
      txe_s2_q <= 1'b0;
      rxe_s1_q <= 1'b0;
      rxe_s2_q <= 1'b0;
    end else if (tick) begin
      txe_s1_q <= mode_q[asu_pkg::BIT_TXE];
      txe_s2_q <= txe_s1_q;
      rxe_s1_q <= mode_q[asu_pkg::BIT_RXE];
      rxe_s2_q <= rxe_s1_q;
    end
  end
  assign tx_on = txe_s2_q && mode_q[asu_pkg::BIT_POWER];
  assign rx_on = rxe_s2_q && mode_q[asu_pkg::BIT_POWER];
  // =====================================================================
  // moves on ticks only, freezes unclocked
  assign tx_load = tick && tx_on && full_q &&
                   ((tx_st_q == asu_pkg::TX_IDLE) ||
                    (tx_st_q == asu_pkg::TX_GAP && tx_cnt_q == asu_pkg::CNT_ZERO));

  // full set by write, cleared on load
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) full_q <= 1'b0;
    else if (wr && hit(PADDR, asu_pkg::OFS_TXBUF)) full_q <= 1'b1;
    else if (tx_load || !mode_q[asu_pkg::BIT_POWER]) full_q <= 1'b0;
  end

  // frame sequencer
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tx_st_q  <= asu_pkg::TX_IDLE;
      tx_cnt_q <= asu_pkg::CNT_ZERO;
      tx_idx_q <= 3'h0;
      tx_sh_q  <= 8'h00;
    end else if (tick) begin
      if (!tx_on) begin
        // disabled: state and bit timer held at reset values
        tx_st_q  <= asu_pkg::TX_IDLE;
        tx_cnt_q <= asu_pkg::CNT_ZERO;
      end else if (tx_load) begin
        tx_sh_q  <= txbuf_q;
        tx_st_q  <= asu_pkg::TX_START;
        tx_cnt_q <= baud_q - asu_pkg::CNT_ONE;
      end else if (tx_cnt_q != asu_pkg::CNT_ZERO) begin
        tx_cnt_q <= tx_cnt_q - asu_pkg::CNT_ONE;
      end else begin
        case (tx_st_q)
          asu_pkg::TX_START: begin
            tx_st_q  <= asu_pkg::TX_DATA;
            tx_idx_q <= 3'h0;
            tx_cnt_q <= baud_q - asu_pkg::CNT_ONE;
          end
          asu_pkg::TX_DATA: begin
            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
            tx_idx_q <= tx_idx_q + 3'h1;
            tx_cnt_q <= baud_q - asu_pkg::CNT_ONE;
            if (tx_idx_q == asu_pkg::LAST_BIT) tx_st_q <= asu_pkg::TX_STOP;
          end
          asu_pkg::TX_STOP: begin
            if (full_q) begin
              tx_st_q  <= asu_pkg::TX_GAP;
              tx_cnt_q <= asu_pkg::GAP_TICKS - asu_pkg::CNT_ONE;
            end else begin
              tx_st_q <= asu_pkg::TX_IDLE;
            end
          end
          asu_pkg::TX_GAP:  tx_st_q <= asu_pkg::TX_IDLE;  // buffer emptied
          default:          tx_st_q <= asu_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // line level from state
  always_comb begin
    case (tx_st_q)
      asu_pkg::TX_START: tx_line = 1'b0;
      asu_pkg::TX_DATA:  tx_line = tx_sh_q[0];
      default:           tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) SERIAL_OUT <= 1'b1;
    else SERIAL_OUT <= tx_line ^ mode_q[asu_pkg::BIT_INV];
  end
  // =====================================================================
  // receiver: input used uninverted, low level starts a frame
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rx_st_q  <= asu_pkg::RX_IDLE;
      rx_cnt_q <= asu_pkg::CNT_ZERO;
      rx_idx_q <= 3'h0;
      rx_sh_q  <= 8'h00;
      rxbuf_q  <= 8'h00;
    end else if (tick) begin
      if (!rx_on) begin
        rx_st_q <= asu_pkg::RX_IDLE;
      end else if (rx_st_q == asu_pkg::RX_IDLE) begin
        if (!SERIAL_IN) begin
          rx_st_q  <= asu_pkg::RX_START;
          rx_cnt_q <= {1'b0, baud_q[7:1]};
        end
      end else if (rx_cnt_q != asu_pkg::CNT_ZERO) begin
        rx_cnt_q <= rx_cnt_q - asu_pkg::CNT_ONE;
      end else begin
        rx_cnt_q <= baud_q - asu_pkg::CNT_ONE;
        case (rx_st_q)
          asu_pkg::RX_START: begin
            rx_idx_q <= 3'h0;
            rx_st_q  <= SERIAL_IN ? asu_pkg::RX_IDLE : asu_pkg::RX_DATA;
          end
          asu_pkg::RX_DATA: begin
            rx_sh_q  <= {SERIAL_IN, rx_sh_q[7:1]};
            rx_idx_q <= rx_idx_q + 3'h1;
            if (rx_idx_q == asu_pkg::LAST_BIT) rx_st_q <= asu_pkg::RX_STOP;
          end
          asu_pkg::RX_STOP: begin
            if (SERIAL_IN) rxbuf_q <= rx_sh_q;
            rx_st_q <= asu_pkg::RX_IDLE;
          end
          default: rx_st_q <= asu_pkg::RX_IDLE;
        endcase
      end
    end
  end
  // =====================================================================
  // events, sticky status, mask, interrupt
  always_comb begin
    ev = 3'h0;
    ev[asu_pkg::EV_TXDONE] = tick && tx_on && !tx_load && tx_st_q == asu_pkg::TX_STOP &&
                             tx_cnt_q == asu_pkg::CNT_ZERO;
    ev[asu_pkg::EV_RXDONE] = tick && rx_on && rx_st_q == asu_pkg::RX_STOP &&
                             rx_cnt_q == asu_pkg::CNT_ZERO && SERIAL_IN;
    ev[asu_pkg::EV_RXERR]  = tick && rx_on && rx_st_q == asu_pkg::RX_STOP &&
                             rx_cnt_q == asu_pkg::CNT_ZERO && !SERIAL_IN;
  end

  // write one clears, new event wins
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) ist_q <= 3'h0;
    else if (wr && hit(PADDR, asu_pkg::OFS_ISTAT)) ist_q <= (ist_q & ~PWDATA[2:0]) | ev;
    else ist_q <= ist_q | ev;
  end

  // level interrupt from masked status
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) IRQ <= 1'b0;
    else IRQ <= |(ist_q & imask_q);
  end
  // =====================================================================
  // checks
  property p_inv_pin;
    @(posedge CLK) disable iff (SYS_RST)
      ($past(tx_st_q) == asu_pkg::TX_IDLE) |-> (SERIAL_OUT == !$past(mode_q[asu_pkg::BIT_INV]));
  endproperty
  a_inv_pin: assert property (p_inv_pin) else $error("idle pin level wrong");
  property p_freeze;
    @(posedge CLK) disable iff (SYS_RST)
      !tick |=> ($stable(tx_st_q) && $stable(rx_st_q) && $stable(tx_cnt_q));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved without base clock");
  property p_en_sync;
    @(posedge CLK) disable iff (SYS_RST)
      $rose(mode_q[asu_pkg::BIT_TXE]) |=> !tx_on;
  endproperty
  a_en_sync: assert property (p_en_sync) else $error("enable passed unsynchronised");
  property p_gap;
    @(posedge CLK) disable iff (SYS_RST)
      (tick && tx_on && tx_st_q == asu_pkg::TX_STOP && tx_cnt_q == asu_pkg::CNT_ZERO && full_q)
      |=> (tx_st_q == asu_pkg::TX_GAP && tx_cnt_q == asu_pkg::GAP_TICKS - asu_pkg::CNT_ONE);
  endproperty
  a_gap: assert property (p_gap) else $error("gap not inserted");
  property p_rx_restart;
    @(posedge CLK) disable iff (SYS_RST)
      (tick && rx_on && rx_st_q == asu_pkg::RX_IDLE && !SERIAL_IN)
      |=> (rx_st_q == asu_pkg::RX_START && rx_cnt_q == {1'b0, baud_q[7:1]});
  endproperty
  a_rx_restart: assert property (p_rx_restart) else $error("start bit not caught");
  property p_full_set;
    @(posedge CLK) disable iff (SYS_RST)
      (wr && hit(PADDR, asu_pkg::OFS_TXBUF)) |=> full_q;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag not set");
  property p_full_clr;
    @(posedge CLK) disable iff (SYS_RST)
      (tx_load && !wr) |=> (!full_q && tx_st_q == asu_pkg::TX_START && tx_sh_q == $past(txbuf_q));
  endproperty
  a_full_clr: assert property (p_full_clr) else $error("load did not clear full");
  property p_irq;
    @(posedge CLK) disable iff (SYS_RST)
      ##1 (IRQ == |($past(ist_q) & $past(imask_q)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule
`default_nettype wire

// >>> tb/asu_remote_node.sv
// remote serial node: decodes the unit's transmit line, drives its receive line
`timescale 1ns/10ps
`default_nettype none
module asu_remote_node (
  input  wire logic        clk,
  input  wire logic        line_in,
  input  wire logic        inv,
  input  wire logic        rx_on,
  input  wire logic [15:0] bit_cyc,
  input  wire logic        send_req,
  input  wire logic [7:0]  send_data,
  output logic             line_out,
  output logic [7:0]       rx_data,
  output logic [7:0]       rx_cnt,
  output logic [31:0]      spacing,
  output logic             send_busy
);
  // ==========================================
  // state
  int unsigned cyc;      // free clock count
  int unsigned t_start;  // clock of last start
  logic [7:0]  sh;       // receive shift
  initial begin
    line_out = 1'b1;
    rx_data = 8'h00;
    rx_cnt = 8'h00;
    spacing = 32'h0;
    send_busy = 1'b0;
    cyc = 0;
    t_start = 0;
  end
  // clock count for start spacing
  always @(posedge clk) cyc <= cyc + 1;
  // ==========================================
  // receiver, mid-bit sampling
  // accepts inverted data
  always begin : rx_proc
    @(posedge clk);
    if (rx_on && (line_in ^ inv) == 1'b0) begin
      spacing = cyc - t_start;
      t_start = cyc;
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk);
        sh[i] = line_in ^ inv;
      end
      repeat (bit_cyc) @(posedge clk);
      rx_data = sh;
      rx_cnt = rx_cnt + 8'h01;
    end
  end
  // ==========================================
  // transmitter, idle high between frames
  // line high outside frames
  always begin : tx_proc
    @(posedge clk);
    if (send_req) begin
      send_busy <= 1'b1;
      line_out <= 1'b0;
      repeat (bit_cyc) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        line_out <= send_data[i];
        repeat (bit_cyc) @(posedge clk);
      end
      line_out <= 1'b1;
      repeat (bit_cyc) @(posedge clk);
      send_busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/asu_top_tb.sv
// self-checking bench for the async serial unit
`timescale 1ns/10ps
`default_nettype none
module asu_top_tb;
  // ==========================================
  // signals
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} asu_row_t;
  logic clk, clk_run, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;            // apb address
  logic [31:0] pwdata, prdata;   // apb data
  logic ser_in, ser_out, irq;    // pins
  logic inv, rx_on, send_req, send_busy, er, hold;
  logic [7:0]  send_data, rx_data, rx_cnt;
  logic [31:0] spacing, rd;      // remote spacing, read data
  int          err_count;        // mismatches
  int          check_count;      // comparisons
  asu_row_t    rows [7] = '{'{asu_pkg::OFS_MODE, 32'h0, 1'b0},
    '{asu_pkg::OFS_CLKSEL, {24'h0, asu_pkg::RST_CLKSEL}, 1'b0},
    '{asu_pkg::OFS_BAUD, {24'h0, asu_pkg::RST_BAUD}, 1'b0},
    '{asu_pkg::OFS_TXSTAT, 32'h0, 1'b0}, '{asu_pkg::OFS_ISTAT, 32'h0, 1'b0},
    '{asu_pkg::OFS_IMASK, 32'h0, 1'b0}, '{8'h20, 32'h0, 1'b1}};
  asu_top i_dut (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out), .IRQ(irq));
  // bit = 16 base clocks of 32 bus clocks
  asu_remote_node i_remote (.clk(clk), .line_in(ser_out), .inv(inv), .rx_on(rx_on),
    .bit_cyc(16'h0200), .send_req(send_req), .send_data(send_data), .line_out(ser_in),
    .rx_data(rx_data), .rx_cnt(rx_cnt), .spacing(spacing), .send_busy(send_busy));
  // ==========================================
  // clock, stoppable
  initial begin
    clk = 1'b0;
    forever begin
      #25;
      if (clk_run) clk = ~clk;
    end
  end
  // ==========================================
  // tasks
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask
  // one apb transfer, idle cycle first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      err_count++;
      report_and_stop;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_reg(rd, exp);
  endtask
  task automatic wait_cnt(input logic [7:0] n);
    int k;
    k = 0;
    while (rx_cnt !== n && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) begin
      err_count++;
      report_and_stop;
    end
  endtask
  task automatic send(input logic [7:0] b);
    int k;
    send_data <= b;
    send_req <= 1'b1;
    @(posedge clk);
    send_req <= 1'b0;
    repeat (2) @(posedge clk);
    // wait for the remote frame to end, bounded
    k = 0;
    while (send_busy !== 1'b0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) begin
      err_count++;
      report_and_stop;
    end
    repeat (600) @(posedge clk);
  endtask
  // ==========================================
  // main sequence
  initial begin
    clk_run = 1'b1;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {inv, send_req, send_data} = '0;
    rx_on = 1'b1;
    err_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    chk_bit(ser_out, 1'b1);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk_reg(rd, rows[i].d);
      chk_bit(er, rows[i].e);
    end
    wr(asu_pkg::OFS_CLKSEL, 32'h1F);
    wr(asu_pkg::OFS_BAUD, 32'h10);
    wr(asu_pkg::OFS_MODE, 32'h80);
    wr(asu_pkg::OFS_MODE, 32'hE0);
    repeat (600) @(posedge clk);
    wr(asu_pkg::OFS_TXBUF, 32'hA5);
    rdc(asu_pkg::OFS_TXSTAT, 32'h2);
    wait_cnt(8'h01);
    chk_reg({24'h0, rx_data}, 32'hA5);
    repeat (1100) @(posedge clk);
    rdc(asu_pkg::OFS_TXSTAT, 32'h0);
    rdc(asu_pkg::OFS_ISTAT, 32'h1);
    chk_bit(irq, 1'b0);
    wr(asu_pkg::OFS_IMASK, 32'h1);
    repeat (3) @(posedge clk);
    chk_bit(irq, 1'b1);
    wr(asu_pkg::OFS_ISTAT, 32'h1);
    repeat (3) @(posedge clk);
    chk_bit(irq, 1'b0);
    // back to back frames, plain mode only
    wr(asu_pkg::OFS_TXBUF, 32'h3C);
    for (int k = 0; k < 200; k++) begin
      apb(1'b0, asu_pkg::OFS_TXSTAT, 32'h0);
      if (rd[1] === 1'b0) break;
    end
    chk_bit(rd[1], 1'b0);
    wr(asu_pkg::OFS_TXBUF, 32'hC3);
    rdc(asu_pkg::OFS_TXSTAT, 32'h3);
    wait_cnt(8'h02);
    chk_reg({24'h0, rx_data}, 32'h3C);
    wait_cnt(8'h03);
    chk_reg({24'h0, rx_data}, 32'hC3);
    // ten bits of 512 clocks plus two base clocks of 32
    chk_reg(spacing, 32'h1440);
    // inverted transmit, plain receive
    repeat (1100) @(posedge clk);
    rx_on <= 1'b0;
    wr(asu_pkg::OFS_MODE, 32'hE1);
    repeat (3) @(posedge clk);
    chk_bit(ser_out, 1'b0);
    inv <= 1'b1;
    rx_on <= 1'b1;
    wr(asu_pkg::OFS_TXBUF, 32'h5A);
    wait_cnt(8'h04);
    chk_reg({24'h0, rx_data}, 32'h5A);
    send(8'h96);
    rdc(asu_pkg::OFS_RXBUF, 32'h96);
    send(8'h69);
    rdc(asu_pkg::OFS_RXBUF, 32'h69);
    rdc(asu_pkg::OFS_ISTAT, 32'h3);
    // clock stop in mid-frame
    wr(asu_pkg::OFS_TXBUF, 32'h77);
    repeat (2000) @(posedge clk);
    hold = ser_out;
    clk_run = 1'b0;
    #20010;
    chk_bit(ser_out, hold);
    clk_run = 1'b1;
    rx_on <= 1'b0;
    wr(asu_pkg::OFS_MODE, 32'h81);
    wr(asu_pkg::OFS_MODE, 32'h00);
    inv <= 1'b0;
    repeat (6000) @(posedge clk);
    chk_bit(ser_out, 1'b1);
    rx_on <= 1'b1;
    wr(asu_pkg::OFS_MODE, 32'h80);
    wr(asu_pkg::OFS_MODE, 32'hE0);
    repeat (600) @(posedge clk);
    wr(asu_pkg::OFS_TXBUF, 32'h81);
    wait_cnt(rx_cnt + 8'h01);
    chk_reg({24'h0, rx_data}, 32'h81);
    report_and_stop;
  end
endmodule
`default_nettype wire
